// file: src/slsf_lane_err_mon.sv
// Per-lane error counters with threshold comparison
`timescale 1ns/1ps
module slsf_lane_err_mon
    import slsf_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic cnt_clear,
    input wire logic [CNT_W-1:0] error_count_threshold,
    // Error events: disparity, invalid code, stray control char
    input wire logic [2:0] err_evt,
    // Flags in the same order
    output logic [2:0] err_flags
);
    logic [CNT_W-1:0] cnt_r [3];
    logic [2:0] flag_r;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_cls
            // Saturating count so a flag never falls back by wrap-around
            always_ff @(posedge aclk) begin
                if (!aresetn || cnt_clear) begin
                    cnt_r[g] <= '0;
                end else if (err_evt[g] && cnt_r[g] != {CNT_W{1'b1}}) begin
                    cnt_r[g] <= CNT_W'(cnt_r[g] + 8'h01); // R13
                end
            end

            // Flag is count at or above the shared threshold
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    flag_r[g] <= 1'b0; // R12
                end else begin
                    flag_r[g] <= (cnt_r[g] >= error_count_threshold); // R10
                end
            end

            a_flag_vs_count: assert property ( // R10
                @(posedge aclk) disable iff (!aresetn)
                $past(aresetn) |->
                flag_r[g] == ($past(cnt_r[g]) >= $past(error_count_threshold)))
                else $error("error flag disagrees with count");

            a_count_saturates: assert property ( // R13
                @(posedge aclk) disable iff (!aresetn || cnt_clear)
                cnt_r[g] == 8'hff |=> cnt_r[g] == 8'hff)
                else $error("error count wrapped");
        end
    endgenerate

    assign err_flags = flag_r;
endmodule : slsf_lane_err_mon

// file: src/slsf_pkg.sv
// Shared constants and types for the lane status flag register bank
package slsf_pkg;
    // Link count and page select width
    localparam int NUM_LINKS = 2;
    localparam int PAGE_W = 1;
    localparam int ADDR_W = 14;
    localparam int CNT_W = 8;
    localparam int IRQ_W = 4;

    // Register indices; byte address is four times the index
    localparam logic [11:0] LINK_PAGE_IDX = 12'h300;
    localparam logic [11:0] LANE5_IDX = 12'h4b5;
    localparam logic [11:0] LANE6_IDX = 12'h4b6;
    localparam logic [11:0] THRESH_IDX = 12'h4c0;
    localparam logic [11:0] CTRL_IDX = 12'h4c1;
    localparam logic [11:0] IRQ_STAT_IDX = 12'h4c2;
    localparam logic [11:0] IRQ_MASK_IDX = 12'h4c3;

    // Status flag bit positions
    localparam int BIT_DISP = 7;
    localparam int BIT_NIT = 6;
    localparam int BIT_UEK = 5;
    localparam int BIT_DESKEW = 4;
    localparam int BIT_ILS = 3;
    localparam int BIT_CKS = 2;
    localparam int BIT_FS = 1;
    localparam int BIT_CGS = 0;

    // Control and interrupt bit positions
    localparam int CTRL_CNT_CLEAR = 0;
    localparam int IRQ_L5_ERR = 0;
    localparam int IRQ_L6_ERR = 1;
    localparam int IRQ_L5_LOSS = 2;
    localparam int IRQ_L6_LOSS = 3;

    // Reset values
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] THRESH_RST = 8'hff;
    localparam logic [PAGE_W-1:0] PAGE_RST = 1'h0;
    localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Decoded register selection
    typedef enum logic [2:0] {
        SLSF_SEL_NONE = 3'b000,
        SLSF_SEL_PAGE = 3'b001,
        SLSF_SEL_LANE5 = 3'b010,
        SLSF_SEL_LANE6 = 3'b011,
        SLSF_SEL_THRESH = 3'b100,
        SLSF_SEL_CTRL = 3'b101,
        SLSF_SEL_ISTAT = 3'b110,
        SLSF_SEL_IMASK = 3'b111
    } slsf_sel_e;

    // Address decode shared by read and write paths
    function automatic slsf_sel_e slsf_decode(input logic [ADDR_W-1:0] a);
        slsf_sel_e s;
        s = SLSF_SEL_NONE;
        if (a[1:0] == 2'h0) begin
            case (a[ADDR_W-1:2])
                LINK_PAGE_IDX: s = SLSF_SEL_PAGE;
                LANE5_IDX: s = SLSF_SEL_LANE5;
                LANE6_IDX: s = SLSF_SEL_LANE6;
                THRESH_IDX: s = SLSF_SEL_THRESH;
                CTRL_IDX: s = SLSF_SEL_CTRL;
                IRQ_STAT_IDX: s = SLSF_SEL_ISTAT;
                IRQ_MASK_IDX: s = SLSF_SEL_IMASK;
                default: s = SLSF_SEL_NONE;
            endcase
        end
        return s;
    endfunction : slsf_decode
endpackage : slsf_pkg

// file: src/slsf_top.sv
// Lane 5 and 6 status flag register bank behind an AXI4-Lite slave
//
// Overview of operation
// R01: Lane 6 bad disparity flag sits in bit 7, set at threshold.
// R02: Invalid code flag of each lane sits in bit 6, set at threshold.
// R03: Stray control character flag sits in bit 5, set at threshold.
// R04: Deskew status sits in bit 4; 1 achieved, 0 failed.
// R05: Lane 5 initial alignment sync sits in bit 3; 1 achieved.
// R06: Lane 5 checksum status sits in bit 2; 1 correct.
// R07: Lane 5 frame sync sits in bit 1; 1 achieved.
// R08: Lane 5 code group sync sits in bit 0; 1 achieved.
// R09: Flags show the link chosen by the page field at 0x300.
// R10: Error flag reads 0 below threshold, 1 at or above it.
// R11: Lane 5 bad disparity flag sits in bit 7, same comparison.
// R12: Status flags reset to 0 and ignore writes.
// R13: Each lane counts each error class; one shared threshold.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
module slsf_top
    import slsf_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Lane 5 receiver events and status, one bit per link
    input wire logic [NUM_LINKS-1:0] lane5_disparity_err_evt,
    input wire logic [NUM_LINKS-1:0] lane5_invalid_code_evt,
    input wire logic [NUM_LINKS-1:0] lane5_stray_control_char_evt,
    input wire logic [NUM_LINKS-1:0] lane5_deskew_ok,
    input wire logic [NUM_LINKS-1:0] lane5_init_align_ok,
    input wire logic [NUM_LINKS-1:0] lane5_checksum_ok,
    input wire logic [NUM_LINKS-1:0] lane5_frame_sync_ok,
    input wire logic [NUM_LINKS-1:0] lane5_code_group_sync_ok,
    // Lane 6 receiver events and status, one bit per link
    input wire logic [NUM_LINKS-1:0] lane6_disparity_err_evt,
    input wire logic [NUM_LINKS-1:0] lane6_invalid_code_evt,
    input wire logic [NUM_LINKS-1:0] lane6_stray_control_char_evt,
    input wire logic [NUM_LINKS-1:0] lane6_deskew_ok,
    // Interrupt
    output logic irq
);
    // Software-visible state
    logic [PAGE_W-1:0] link_page_r;
    logic [CNT_W-1:0] error_count_threshold_r;
    logic cnt_clear_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_stat_nxt;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [7:0] lane5_link_flags_r;
    logic [7:0] lane6_link_flags_r;

    // Per-link flag images
    logic [7:0] lane5_img [NUM_LINKS];
    logic [7:0] lane6_img [NUM_LINKS];
    logic [NUM_LINKS-1:0] l5_err_rise;
    logic [NUM_LINKS-1:0] l6_err_rise;
    logic [NUM_LINKS-1:0] l5_loss;
    logic [NUM_LINKS-1:0] l6_loss;

    // Bus state
    logic aw_got_r;
    logic w_got_r;
    logic [ADDR_W-1:0] waddr_r;
    logic [7:0] wdata_r;
    logic wstrb0_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic wr_go;
    slsf_sel_e wsel;
    slsf_sel_e rsel;
    logic [7:0] rd_val;

    genvar l;
    generate
        for (l = 0; l < NUM_LINKS; l++) begin : g_link
            logic [2:0] err5;
            logic [2:0] err6;
            logic [2:0] err5_q;
            logic [2:0] err6_q;
            logic [4:0] stat5_r;
            logic stat6_r;

            // Lane 5 counters, one set per link
            slsf_lane_err_mon u_lane5 (
                .aclk(aclk),
                .aresetn(aresetn),
                .cnt_clear(cnt_clear_r),
                .error_count_threshold(error_count_threshold_r),
                .err_evt({lane5_stray_control_char_evt[l],
                          lane5_invalid_code_evt[l],
                          lane5_disparity_err_evt[l]}),
                .err_flags(err5)
            );

            // Lane 6 counters share the same threshold
            slsf_lane_err_mon u_lane6 (
                .aclk(aclk),
                .aresetn(aresetn),
                .cnt_clear(cnt_clear_r),
                .error_count_threshold(error_count_threshold_r),
                .err_evt({lane6_stray_control_char_evt[l],
                          lane6_invalid_code_evt[l],
                          lane6_disparity_err_evt[l]}),
                .err_flags(err6)
            );

            // Capture sync levels and previous flags for edge events
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    stat5_r <= 5'h00;
                    stat6_r <= 1'b0;
                    err5_q <= 3'h0;
                    err6_q <= 3'h0;
                end else begin
                    stat5_r <= {lane5_deskew_ok[l], lane5_init_align_ok[l],
                                lane5_checksum_ok[l], lane5_frame_sync_ok[l],
                                lane5_code_group_sync_ok[l]};
                    stat6_r <= lane6_deskew_ok[l];
                    err5_q <= err5;
                    err6_q <= err6;
                end
            end

            // Bit packing of each lane's image
            always_comb begin
                lane5_img[l] = FLAGS_RST;
                lane5_img[l][BIT_DISP] = err5[0]; // R11
                lane5_img[l][BIT_NIT] = err5[1]; // R02
                lane5_img[l][BIT_UEK] = err5[2]; // R03
                lane5_img[l][BIT_DESKEW] = stat5_r[4]; // R04
                lane5_img[l][BIT_ILS] = stat5_r[3]; // R05
                lane5_img[l][BIT_CKS] = stat5_r[2]; // R06
                lane5_img[l][BIT_FS] = stat5_r[1]; // R07
                lane5_img[l][BIT_CGS] = stat5_r[0]; // R08
                lane6_img[l] = FLAGS_RST;
                lane6_img[l][BIT_DISP] = err6[0]; // R01
                lane6_img[l][BIT_NIT] = err6[1]; // R02
                lane6_img[l][BIT_UEK] = err6[2]; // R03
                lane6_img[l][BIT_DESKEW] = stat6_r; // R04
            end

            // Events for the interrupt unit, from every link
            assign l5_err_rise[l] = |(err5 & ~err5_q);
            assign l6_err_rise[l] = |(err6 & ~err6_q);
            assign l5_loss[l] = |(stat5_r & ~{lane5_deskew_ok[l],
                lane5_init_align_ok[l], lane5_checksum_ok[l],
                lane5_frame_sync_ok[l], lane5_code_group_sync_ok[l]});
            assign l6_loss[l] = stat6_r & ~lane6_deskew_ok[l];
        end
    endgenerate

    // Visible flags follow the paged link; registered for clean reads
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lane5_link_flags_r <= FLAGS_RST; // R12
            lane6_link_flags_r <= FLAGS_RST; // R12
        end else begin
            lane5_link_flags_r <= lane5_img[link_page_r]; // R09
            lane6_link_flags_r <= lane6_img[link_page_r]; // R09
        end
    end

    a_view_follows_page: assert property ( // R09
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |->
        lane5_link_flags_r == $past(lane5_img[link_page_r]))
        else $error("lane 5 flags not from selected link");

    a_lane6_disp_bit: assert property ( // R01
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |->
        lane6_link_flags_r[BIT_DISP] ==
        $past(lane6_img[link_page_r][BIT_DISP]))
        else $error("lane 6 disparity bit wrong");

    a_flags_reset_zero: assert property ( // R12
        @(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |->
        lane5_link_flags_r == 8'h00 && lane6_link_flags_r == 8'h00)
        else $error("flags not zero after reset");

    // Write channel: address and data taken in either order
    assign s_axi_awready = !aw_got_r && !bvalid_r;
    assign s_axi_wready = !w_got_r && !bvalid_r;
    assign wr_go = aw_got_r && w_got_r;
    assign wsel = slsf_decode(waddr_r);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            waddr_r <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r <= 1'b1;
            waddr_r <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_got_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_r <= 1'b0;
            wdata_r <= 8'h00;
            wstrb0_r <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata[7:0];
            wstrb0_r <= s_axi_wstrb[0];
        end else if (wr_go) begin
            w_got_r <= 1'b0;
        end
    end

    // Response one cycle after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= (wsel == SLSF_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    sequence s_both_held;
        aw_got_r && w_got_r;
    endsequence

    a_write_answered: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_both_held |=> bvalid_r ##0 !aw_got_r && !w_got_r)
        else $error("write not answered one cycle after both halves");

    // Writable controls; lane flag registers are read-only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_page_r <= PAGE_RST;
            error_count_threshold_r <= THRESH_RST;
            irq_mask_r <= IRQ_RST;
        end else if (wr_go && wstrb0_r) begin
            case (wsel)
                SLSF_SEL_PAGE: link_page_r <= wdata_r[PAGE_W-1:0]; // R09
                SLSF_SEL_THRESH: error_count_threshold_r <= wdata_r; // R13
                SLSF_SEL_IMASK: irq_mask_r <= wdata_r[IRQ_W-1:0];
                default: link_page_r <= link_page_r; // R12
            endcase
        end
    end

    // Counter clear is a one-cycle pulse; it does not hold counts at 0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_clear_r <= 1'b0;
        end else begin
            cnt_clear_r <= wr_go && wstrb0_r && wsel == SLSF_SEL_CTRL &&
                           wdata_r[CTRL_CNT_CLEAR];
        end
    end

    // Sticky status; a new event beats a same-cycle clear
    always_comb begin
        irq_stat_nxt = irq_stat_r;
        if (wr_go && wstrb0_r && wsel == SLSF_SEL_ISTAT) begin
            irq_stat_nxt = irq_stat_r & ~wdata_r[IRQ_W-1:0];
        end
        irq_stat_nxt[IRQ_L5_ERR] = irq_stat_nxt[IRQ_L5_ERR] | (|l5_err_rise);
        irq_stat_nxt[IRQ_L6_ERR] = irq_stat_nxt[IRQ_L6_ERR] | (|l6_err_rise);
        irq_stat_nxt[IRQ_L5_LOSS] = irq_stat_nxt[IRQ_L5_LOSS] | (|l5_loss);
        irq_stat_nxt[IRQ_L6_LOSS] = irq_stat_nxt[IRQ_L6_LOSS] | (|l6_loss);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_r <= IRQ_RST;
        end else begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    a_set_beats_clear: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (|l5_err_rise) |=> irq_stat_r[IRQ_L5_ERR])
        else $error("error event lost against clear");

    a_irq_from_mask: assert property (
        @(posedge aclk) disable iff (!aresetn)
        irq_mask_r == 4'h0 |-> !irq)
        else $error("interrupt raised while fully masked");

    // Read channel: one read in flight, data registered
    assign s_axi_arready = !rvalid_r;
    assign rsel = slsf_decode(s_axi_araddr);

    always_comb begin
        rd_val = 8'h00;
        case (rsel)
            SLSF_SEL_PAGE: rd_val = {{(8-PAGE_W){1'b0}}, link_page_r};
            SLSF_SEL_LANE5: rd_val = lane5_link_flags_r;
            SLSF_SEL_LANE6: rd_val = lane6_link_flags_r;
            SLSF_SEL_THRESH: rd_val = error_count_threshold_r;
            SLSF_SEL_CTRL: rd_val = 8'h00;
            SLSF_SEL_ISTAT: rd_val = {4'h0, irq_stat_r};
            SLSF_SEL_IMASK: rd_val = {4'h0, irq_mask_r};
            default: rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rdata_r <= {24'h00_0000, rd_val};
            rresp_r <= (rsel == SLSF_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    sequence s_read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    a_read_answered: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_read_taken |=> rvalid_r ##0 rdata_r[31:8] == 24'h00_0000)
        else $error("read not answered next cycle");

    a_unmapped_slverr: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_read_taken and (rsel == SLSF_SEL_NONE) |=>
        rresp_r == RESP_SLVERR && rdata_r == 32'h0000_0000)
        else $error("unmapped read not refused");
endmodule : slsf_top

// file: test/slsf_lane_model.sv
// Far-side lane receiver model: status levels and error pulses
`timescale 1ns/1ps
module slsf_lane_model
    import slsf_pkg::*;
(
    // Clock
    input wire logic aclk,
    // Lane 5 error pulses and status levels
    output logic [NUM_LINKS-1:0] lane5_disparity_err_evt,
    output logic [NUM_LINKS-1:0] lane5_invalid_code_evt,
    output logic [NUM_LINKS-1:0] lane5_stray_control_char_evt,
    output logic [NUM_LINKS-1:0] lane5_deskew_ok,
    output logic [NUM_LINKS-1:0] lane5_init_align_ok,
    output logic [NUM_LINKS-1:0] lane5_checksum_ok,
    output logic [NUM_LINKS-1:0] lane5_frame_sync_ok,
    output logic [NUM_LINKS-1:0] lane5_code_group_sync_ok,
    // Lane 6 error pulses and deskew level
    output logic [NUM_LINKS-1:0] lane6_disparity_err_evt,
    output logic [NUM_LINKS-1:0] lane6_invalid_code_evt,
    output logic [NUM_LINKS-1:0] lane6_stray_control_char_evt,
    output logic [NUM_LINKS-1:0] lane6_deskew_ok
);
    // Pulse index is class*2+link; level index is kind*2+link
    logic [5:0] ev5 = 6'h00;
    logic [5:0] ev6 = 6'h00;
    logic [9:0] st5 = 10'h000;
    logic [1:0] st6 = 2'h0;

    // Fan the packed vectors out to the lane pins
    assign lane5_disparity_err_evt = ev5[1:0];
    assign lane5_invalid_code_evt = ev5[3:2];
    assign lane5_stray_control_char_evt = ev5[5:4];
    assign lane6_disparity_err_evt = ev6[1:0];
    assign lane6_invalid_code_evt = ev6[3:2];
    assign lane6_stray_control_char_evt = ev6[5:4];
    assign lane5_deskew_ok = st5[1:0];
    assign lane5_init_align_ok = st5[3:2];
    assign lane5_checksum_ok = st5[5:4];
    assign lane5_frame_sync_ok = st5[7:6];
    assign lane5_code_group_sync_ok = st5[9:8];
    assign lane6_deskew_ok = st6;

    // Levels change right after an edge and then stand
    task automatic set_levels(input logic [9:0] s5, input logic [1:0] s6);
        @(posedge aclk);
        st5 <= s5;
        st6 <= s6;
    endtask : set_levels

    // Held high n cycles, so n errors back to back
    task automatic pulse(input int ln, input int idx, input int n);
        @(posedge aclk);
        if (ln == 0) ev5[idx] <= 1'b1; else ev6[idx] <= 1'b1;
        repeat (n) @(posedge aclk);
        ev5 <= 6'h00;
        ev6 <= 6'h00;
    endtask : pulse
endmodule : slsf_lane_model

// file: test/testbench.sv
// Self-checking bench for the lane status flag register bank
`timescale 1ns/1ps
module testbench import slsf_pkg::*; ;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic [ADDR_W-1:0] s_axi_awaddr = 14'h0, s_axi_araddr = 14'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [NUM_LINKS-1:0] lane5_disparity_err_evt, lane5_invalid_code_evt;
    logic [NUM_LINKS-1:0] lane5_stray_control_char_evt, lane5_deskew_ok;
    logic [NUM_LINKS-1:0] lane5_init_align_ok, lane5_checksum_ok;
    logic [NUM_LINKS-1:0] lane5_frame_sync_ok, lane5_code_group_sync_ok;
    logic [NUM_LINKS-1:0] lane6_disparity_err_evt, lane6_invalid_code_evt;
    logic [NUM_LINKS-1:0] lane6_stray_control_char_evt, lane6_deskew_ok;
    // Reference model state
    int cnt[2][3][2];
    int thr, fails, total_checks;
    logic [9:0] m5;
    logic [1:0] m6;
    logic [3:0] istat, imask;
    logic [7:0] pf[2][2];
    logic [31:0] rng = 32'h00014627;

    slsf_top dut (.*);
    slsf_lane_model far (.*);

    // 250 MHz clock
    always #2 aclk = ~aclk;

    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xs

    // Expected flag byte of one lane on one link
    function automatic logic [7:0] mflags(int ln, int lk);
        logic [7:0] f;
        f = 8'h00;
        for (int c = 0; c < 3; c++) f[7-c] = cnt[ln][c][lk] >= thr;
        for (int s = 0; s < 5 && ln == 0; s++) f[4-s] = m5[s*2+lk];
        if (ln == 1) f[4] = m6[lk];
        return f;
    endfunction : mflags

    // Sticky events: error flag rose, status flag fell
    task automatic mupd();
        logic [7:0] n;
        for (int ln = 0; ln < 2; ln++) begin
            for (int lk = 0; lk < 2; lk++) begin
                n = mflags(ln, lk);
                if (|(n[7:5] & ~pf[ln][lk][7:5])) istat[ln] = 1'b1;
                if (|(pf[ln][lk][4:0] & ~n[4:0])) istat[2+ln] = 1'b1;
                pf[ln][lk] = n;
            end
        end
    endtask : mupd

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk_val

    task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected resp at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk_resp

    // A wait that ran out counts as a mismatch
    task automatic tmo(input bit ok);
        if (!ok) begin
            fails++;
            results();
        end
    endtask : tmo

    // Address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [11:0] idx, input logic [7:0] d,
            input logic [1:0] er);
        bit aw, w, bd;
        aw = 0;
        w = 0;
        bd = 0;
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (int n = 0; n < 60 && !bd; n++) begin
            @(posedge aclk);
            bd = aw && w && s_axi_bvalid;
            if (!aw && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (!w && s_axi_wready) s_axi_wvalid <= 1'b0;
            aw |= s_axi_awready;
            w |= s_axi_wready;
        end
        tmo(bd);
        chk_resp(s_axi_bresp, er);
    endtask : axi_wr

    task automatic rd_chk(input logic [11:0] idx, input logic [31:0] e,
            input logic [1:0] er);
        bit rd;
        rd = 0;
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        for (int n = 0; n < 60 && !rd; n++) begin
            @(posedge aclk);
            rd = s_axi_rvalid;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        tmo(rd);
        chk_resp(s_axi_rresp, er);
        chk_val(s_axi_rdata, e);
    endtask : rd_chk

    // Both link pages of both lanes against the model
    task automatic check_pages();
        for (int pg = 0; pg < 2; pg++) begin
            axi_wr(LINK_PAGE_IDX, 8'(pg), RESP_OKAY);
            rd_chk(LANE5_IDX, {24'h0, mflags(0, pg)}, RESP_OKAY);
            rd_chk(LANE6_IDX, {24'h0, mflags(1, pg)}, RESP_OKAY);
        end
    endtask : check_pages

    task automatic bump(input int ln, input int c, input int lk, input int n);
        far.pulse(ln, c * 2 + lk, n);
        cnt[ln][c][lk] = (cnt[ln][c][lk] + n > 255) ? 255 : cnt[ln][c][lk] + n;
        mupd();
        repeat (5) @(posedge aclk);
    endtask : bump

    task automatic irq_chk();
        repeat (3) @(negedge aclk);
        chk_val({31'h0, irq}, {31'h0, |(istat & imask)});
        @(posedge aclk);
    endtask : irq_chk

    // Main sequence
    initial begin
        logic [31:0] r;
        thr = 255;
        m5 = 10'h000;
        m6 = 2'h0;
        istat = 4'h0;
        imask = 4'h0;
        cnt = '{default: 0};
        pf = '{default: 8'h00};
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(LANE5_IDX, 32'h0, RESP_OKAY);
        s_axi_wstrb <= 4'h0;
        axi_wr(THRESH_IDX, 8'h00, RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rd_chk(THRESH_IDX, {24'h0, THRESH_RST}, RESP_OKAY);
        rd_chk(12'h123, 32'h0, RESP_SLVERR);
        axi_wr(12'h124, 8'h5a, RESP_SLVERR);
        axi_wr(LANE5_IDX, 8'hff, RESP_OKAY);
        axi_wr(LANE6_IDX, 8'hff, RESP_OKAY);
        check_pages();
        rd_chk(LINK_PAGE_IDX, 32'h1, RESP_OKAY);
        // Random status levels on both links
        for (int i = 0; i < 8; i++) begin
            r = xs();
            m5 = r[9:0];
            m6 = r[17:16];
            far.set_levels(m5, m6);
            mupd();
            repeat (4) @(posedge aclk);
            check_pages();
        end
        // Threshold edge: one below, then exactly at it
        thr = 3;
        axi_wr(THRESH_IDX, 8'h03, RESP_OKAY);
        for (int ln = 0; ln < 2; ln++) begin
            for (int c = 0; c < 3; c++) begin
                for (int lk = 0; lk < 2; lk++) begin
                    bump(ln, c, lk, 2);
                    check_pages();
                    bump(ln, c, lk, 1);
                    check_pages();
                end
            end
        end
        bump(0, 0, 0, 255);
        // Interrupt: raised, masked, cleared
        rd_chk(IRQ_STAT_IDX, {28'h0, istat}, RESP_OKAY);
        irq_chk();
        imask = 4'hb;
        axi_wr(IRQ_MASK_IDX, 8'h0b, RESP_OKAY);
        rd_chk(IRQ_MASK_IDX, 32'hb, RESP_OKAY);
        irq_chk();
        axi_wr(IRQ_STAT_IDX, {4'h0, istat}, RESP_OKAY);
        istat = 4'h0;
        irq_chk();
        rd_chk(IRQ_STAT_IDX, 32'h0, RESP_OKAY);
        // Counter clear drops every error flag
        axi_wr(CTRL_IDX, 8'h01, RESP_OKAY);
        cnt = '{default: 0};
        mupd();
        repeat (4) @(posedge aclk);
        check_pages();
        results();
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (60000) @(posedge aclk);
        tmo(1'b0);
    end
endmodule : testbench
